// ### logic/asc_pkg.sv
// Notes on behaviour
// - write ends at first deasserting strobe
// - drive bus only after memory outputs off
// - every cycle at least cycle time long
// - write pulse and address-to-end minimums
// - chip selects held before write end
// - data setup before write end, hold zero
// - address steady from write start to end
// - address changes only while deselected
// - wait one cycle time after retention
package asc_pkg;

  // ==========================================================
  // geometry
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int CNT_W = 8;

  // ==========================================================
  // timing of the fastest grade, in ns
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_RC_NS = 35;
  localparam int T_AA_NS = 35;
  localparam int T_OE_NS = 15;
  localparam int T_WP_NS = 10;
  localparam int T_AW_NS = 10;
  localparam int T_CW_NS = 12;
  localparam int T_DW_NS = 8;
  localparam int T_HZ_NS = 6;
  localparam int T_OW_NS = 1;

  // least time to whole cycles, never below one
  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ceil_cyc

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : max2

  // ==========================================================
  // cycle counts, loaded as count minus one
  localparam int RD_CYC = max2(max2(ceil_cyc(T_AA_NS), ceil_cyc(T_OE_NS)), ceil_cyc(T_RC_NS));
  localparam int WP_CYC = max2(max2(ceil_cyc(T_WP_NS), ceil_cyc(T_AW_NS)),
                               max2(ceil_cyc(T_CW_NS), ceil_cyc(T_DW_NS)));
  localparam int OFF_CYC = max2(ceil_cyc(T_HZ_NS), ceil_cyc(T_OW_NS));
  localparam int REC_CYC = ceil_cyc(T_RC_NS);
  localparam logic [CNT_W-1:0] RD_LOAD = CNT_W'(RD_CYC - 1);
  localparam logic [CNT_W-1:0] WP_LOAD = CNT_W'(WP_CYC - 1);
  localparam logic [CNT_W-1:0] OFF_LOAD = CNT_W'(OFF_CYC - 1);
  localparam logic [CNT_W-1:0] REC_LOAD = CNT_W'(REC_CYC - 1);
  localparam logic [CNT_W-1:0] ONE_LOAD = 8'h00;

  // ==========================================================
  // controller states, gray along each path up to the step back to idle
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_RD_ACC  = 3'h1,
    ST_RD_OFF  = 3'h3,
    ST_WR_SET  = 3'h2,
    ST_WR_PUL  = 3'h6,
    ST_WR_END  = 3'h7,
    ST_RETAIN  = 3'h4,
    ST_RECOVER = 3'h5
  } asc_state_e;

endpackage : asc_pkg

// ### logic/asc_sram_host.sv
`timescale 1ns/1ps
// ==========================================================
// host controller for a 128K x 8 asynchronous static memory
module asc_sram_host #(
  parameter int ADDR_W = asc_pkg::ADDR_W,
  parameter int DATA_W = asc_pkg::DATA_W
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // user request side
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [DATA_W-1:0] req_wdata_in,
  output logic req_ready_out,
  output logic rd_valid_out,
  output logic [DATA_W-1:0] rd_data_out,
  output logic wr_done_out,
  // low-power retention request
  input wire logic retention_in,
  // memory pins
  output logic [ADDR_W-1:0] word_address_out,
  output logic chip_select_low_active_n_out,
  output logic chip_select_high_active_out,
  output logic write_strobe_n_out,
  output logic output_gate_n_out,
  input wire logic [DATA_W-1:0] data_bus_in,
  output logic [DATA_W-1:0] data_bus_out,
  output logic data_bus_oe_out
);

  // ==========================================================
  // state and pin registers
  asc_pkg::asc_state_e state_r;
  asc_pkg::asc_state_e state_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] wdata_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic rd_valid_r;
  logic rd_valid_nxt;
  logic wr_done_r;
  logic wr_done_nxt;
  logic sel_r;
  logic sel_nxt;
  logic we_n_r;
  logic we_n_nxt;
  logic og_n_r;
  logic og_n_nxt;
  logic drv_r;
  logic drv_nxt;

  // ==========================================================
  // wait timer
  asc_tmr_if #(.CNT_W(asc_pkg::CNT_W)) tif ();

  asc_wait_timer #(
    .CNT_W(asc_pkg::CNT_W)
  ) asc_wait_timer_i (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .tif(tif)
  );

  // ==========================================================
  // request decode
  wire in_idle = (state_r == asc_pkg::ST_IDLE);
  wire can_take = in_idle && !retention_in;
  wire take = can_take && req_valid_in;
  wire take_rd = take && !req_write_in;
  wire take_wr = take && req_write_in;
  wire wait_done = tif.done;

  assign req_ready_out = can_take;

  // ==========================================================
  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      asc_pkg::ST_IDLE: begin
        if (retention_in) begin
          state_nxt = asc_pkg::ST_RETAIN;
        end else if (take_rd) begin
          state_nxt = asc_pkg::ST_RD_ACC;
        end else if (take_wr) begin
          state_nxt = asc_pkg::ST_WR_SET;
        end
      end
      // hold select and gate for access and cycle time
      asc_pkg::ST_RD_ACC: begin
        if (wait_done) begin
          state_nxt = asc_pkg::ST_RD_OFF;
        end
      end
      // let memory outputs float before anything else
      asc_pkg::ST_RD_OFF: begin
        if (wait_done) begin
          state_nxt = asc_pkg::ST_IDLE;
        end
      end
      // address, selects and data set up, strobe high
      asc_pkg::ST_WR_SET: begin
        state_nxt = asc_pkg::ST_WR_PUL;
      end
      asc_pkg::ST_WR_PUL: begin
        if (wait_done) begin
          state_nxt = asc_pkg::ST_WR_END;
        end
      end
      // strobe released first, selects and data held one cycle
      asc_pkg::ST_WR_END: begin
        if (wait_done) begin
          state_nxt = asc_pkg::ST_IDLE;
        end
      end
      asc_pkg::ST_RETAIN: begin
        if (!retention_in) begin
          state_nxt = asc_pkg::ST_RECOVER;
        end
      end
      asc_pkg::ST_RECOVER: begin
        if (wait_done) begin
          state_nxt = asc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = asc_pkg::ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // timer loading on each state entry
  assign tif.load = (state_nxt != state_r);
  assign tif.load_val =
    (state_nxt == asc_pkg::ST_RD_ACC)  ? asc_pkg::RD_LOAD :
    (state_nxt == asc_pkg::ST_RD_OFF)  ? asc_pkg::OFF_LOAD :
    (state_nxt == asc_pkg::ST_WR_PUL)  ? asc_pkg::WP_LOAD :
    (state_nxt == asc_pkg::ST_RECOVER) ? asc_pkg::REC_LOAD :
    asc_pkg::ONE_LOAD;

  // ==========================================================
  // pin levels for the coming state
  wire nxt_rd = (state_nxt == asc_pkg::ST_RD_ACC);
  wire nxt_wset = (state_nxt == asc_pkg::ST_WR_SET);
  wire nxt_wpul = (state_nxt == asc_pkg::ST_WR_PUL);
  wire nxt_wend = (state_nxt == asc_pkg::ST_WR_END);
  wire nxt_wr = nxt_wset || nxt_wpul || nxt_wend;

  // both selects move together, deselected outside a cycle
  assign sel_nxt = nxt_rd || nxt_wr;
  // gate low only for a read, never while writing
  assign og_n_nxt = !nxt_rd;
  // strobe low only inside the pulse, selects already up
  assign we_n_nxt = !nxt_wpul;
  // data driven only while the gate is high
  assign drv_nxt = nxt_wr;

  // ==========================================================
  // address and data capture
  // address loads only in idle, when both selects are off
  assign addr_nxt = take ? req_addr_in : addr_r;
  assign wdata_nxt = take_wr ? req_wdata_in : wdata_r;
  // sample the bus on the last access cycle, gate still low
  wire rd_sample = (state_r == asc_pkg::ST_RD_ACC) && wait_done;
  assign rdata_nxt = rd_sample ? data_bus_in : rdata_r;
  assign rd_valid_nxt = rd_sample;
  assign wr_done_nxt = (state_r == asc_pkg::ST_WR_END) && wait_done;

  // ==========================================================
  // state register
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r <= asc_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // pin registers, safe deselected levels in reset
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sel_r <= 1'b0;
      we_n_r <= 1'b1;
      og_n_r <= 1'b1;
      drv_r <= 1'b0;
    end else begin
      sel_r <= sel_nxt;
      we_n_r <= we_n_nxt;
      og_n_r <= og_n_nxt;
      drv_r <= drv_nxt;
    end
  end

  // address and data registers
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      addr_r <= '0;
      wdata_r <= '0;
      rdata_r <= '0;
    end else begin
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // completion pulses
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_valid_r <= 1'b0;
      wr_done_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_valid_nxt;
      wr_done_r <= wr_done_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign word_address_out = addr_r;
  assign chip_select_low_active_n_out = !sel_r;
  assign chip_select_high_active_out = sel_r;
  assign write_strobe_n_out = we_n_r;
  assign output_gate_n_out = og_n_r;
  assign data_bus_out = wdata_r;
  assign data_bus_oe_out = drv_r;
  assign rd_valid_out = rd_valid_r;
  assign rd_data_out = rdata_r;
  assign wr_done_out = wr_done_r;

endmodule : asc_sram_host

// ### logic/asc_tmr_if.sv
`timescale 1ns/1ps
// ==========================================================
// wait timer carrier between controller and timer
interface asc_tmr_if #(parameter int CNT_W = 8);
  logic load;
  logic [CNT_W-1:0] load_val;
  logic done;
  modport ctl (output load, output load_val, input done);
  modport tmr (input load, input load_val, output done);
endinterface : asc_tmr_if

// ### logic/asc_wait_timer.sv
`timescale 1ns/1ps
// ==========================================================
// down counter; done while the count is spent
module asc_wait_timer #(
  parameter int CNT_W = 8
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  asc_tmr_if.tmr tif
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  // reload on state entry, else count toward zero
  assign cnt_nxt = tif.load ? tif.load_val :
                   (cnt_r != '0) ? cnt_r - CNT_W'(1) : cnt_r;
  // done from the count alone: the load is decoded from the next state,
  // which itself waits on done, so gating with load would close a loop
  assign tif.done = (cnt_r == '0);

  // count register
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule : asc_wait_timer

// ### verif/asc_sram_host_monitor.sv
`timescale 1ns/1ps
// ==========================================================
// pin protocol checker for the host
module asc_sram_host_monitor (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [asc_pkg::ADDR_W-1:0] req_addr_in,
  input wire logic req_ready_out,
  input wire logic rd_valid_out,
  input wire logic wr_done_out,
  input wire logic retention_in,
  input wire logic [asc_pkg::ADDR_W-1:0] word_address_out,
  input wire logic chip_select_low_active_n_out,
  input wire logic chip_select_high_active_out,
  input wire logic write_strobe_n_out,
  input wire logic output_gate_n_out,
  input wire logic data_bus_oe_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic rd_take;
  logic wr_take;
  // requests taken at this edge
  assign rd_take = req_valid_in && req_ready_out && !req_write_in;
  assign wr_take = req_valid_in && req_ready_out && req_write_in;

  AST_SEL_PAIR: assert property (
    chip_select_high_active_out == !chip_select_low_active_n_out)
    else $error("select pins not complementary");
  AST_NO_CLASH: assert property (data_bus_oe_out |-> output_gate_n_out)
    else $error("host drives bus while gate low");
  AST_WR_GATE: assert property (
    !write_strobe_n_out |-> output_gate_n_out && data_bus_oe_out)
    else $error("strobe low without data or with gate");
  AST_ADDR_MOVE: assert property (
    !$stable(word_address_out) |-> $past(chip_select_low_active_n_out))
    else $error("address moved while selected");
  AST_WR_SEQ: assert property (
    $fell(write_strobe_n_out) |-> $past(data_bus_oe_out) && !chip_select_low_active_n_out
    ##1 write_strobe_n_out && !chip_select_low_active_n_out && $stable(word_address_out))
    else $error("write pulse framing wrong");
  AST_RD_PINS: assert property (rd_take |=> !output_gate_n_out && write_strobe_n_out
    && !chip_select_low_active_n_out && word_address_out == $past(req_addr_in))
    else $error("read pins wrong");
  AST_RD_LAT: assert property (rd_take |-> ##2 rd_valid_out)
    else $error("read answer late");
  AST_WR_LAT: assert property (wr_take |-> ##4 wr_done_out)
    else $error("write answer late");
  AST_RETAIN: assert property (retention_in |-> !req_ready_out)
    else $error("ready during retention");
endmodule : asc_sram_host_monitor

bind asc_sram_host asc_sram_host_monitor asc_sram_host_monitor_i (.core_clk_in, .sys_rst_in,
  .req_valid_in, .req_write_in, .req_addr_in, .req_ready_out, .rd_valid_out, .wr_done_out,
  .retention_in, .word_address_out, .chip_select_low_active_n_out,
  .chip_select_high_active_out, .write_strobe_n_out, .output_gate_n_out, .data_bus_oe_out);

// ### verif/asc_sram_model.sv
`timescale 1ns/1ps
// ==========================================================
// zero-delay memory device model
module asc_sram_model (
  input wire logic [asc_pkg::ADDR_W-1:0] addr_in,
  input wire logic sel_n_in,
  input wire logic sel_in,
  input wire logic wr_n_in,
  input wire logic gate_n_in,
  input wire logic [asc_pkg::DATA_W-1:0] dq_in,
  output logic [asc_pkg::DATA_W-1:0] dq_out
);
  logic [7:0] mem [0:131071];
  logic [7:0] last_q = 8'h00;
  logic on_w;
  logic drv_w;
  logic wr_w;
  logic armed = 1'b0;
  // selection needs both enables, either one deselects
  assign on_w = !sel_n_in && sel_in;
  assign drv_w = on_w && !gate_n_in && wr_n_in;
  assign wr_w = on_w && !wr_n_in;
  // access, turn-on and release all at zero delay; idle bus shows inverse
  assign dq_out = drv_w ? mem[addr_in] : ~last_q;
  always @(posedge drv_w) last_q = mem[addr_in];
  // write lands when strobe or an enable lets go
  always @(posedge wr_w) armed = 1'b1;
  always @(negedge wr_w) if (armed) mem[addr_in] = dq_in;
endmodule : asc_sram_model

// ### verif/tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// testbench
module tb_top;
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic req_valid_in = 1'b0;
  logic req_write_in = 1'b0;
  logic retention_in = 1'b0;
  logic [16:0] req_addr_in = 17'h00000;
  logic [16:0] word_address_out;
  logic [7:0] req_wdata_in = 8'h00;
  logic [7:0] rd_data_out, data_bus_out, mem_q;
  logic req_ready_out, rd_valid_out, wr_done_out, data_bus_oe_out;
  logic chip_select_low_active_n_out, chip_select_high_active_out;
  logic write_strobe_n_out, output_gate_n_out;
  wire logic [7:0] data_bus_in = data_bus_oe_out ? data_bus_out : mem_q;
  int num_errors = 0;
  int tests_run = 0;

  always #50 core_clk_in = ~core_clk_in;

  asc_sram_host asc_sram_host_i (.core_clk_in, .sys_rst_in, .req_valid_in, .req_write_in,
    .req_addr_in, .req_wdata_in, .req_ready_out, .rd_valid_out, .rd_data_out, .wr_done_out,
    .retention_in, .word_address_out, .chip_select_low_active_n_out,
    .chip_select_high_active_out, .write_strobe_n_out, .output_gate_n_out, .data_bus_in,
    .data_bus_out, .data_bus_oe_out);
  asc_sram_model asc_sram_model_i (.addr_in(word_address_out),
    .sel_n_in(chip_select_low_active_n_out), .sel_in(chip_select_high_active_out),
    .wr_n_in(write_strobe_n_out), .gate_n_in(output_gate_n_out), .dq_in(data_bus_in),
    .dq_out(mem_q));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask : check

  task finish_test;
    if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // one request, held until taken
  task do_req(input logic w, input logic [16:0] a, input logic [7:0] d);
    int n;
    @(posedge core_clk_in);
    req_valid_in <= 1'b1;
    req_write_in <= w;
    req_addr_in <= a;
    req_wdata_in <= d;
    n = 0;
    do begin
      @(negedge core_clk_in);
      n++;
    end while (req_ready_out !== 1'b1 && n < 20);
    @(posedge core_clk_in);
    req_valid_in <= 1'b0;
  endtask : do_req

  task automatic wait_pulse(ref logic p);
    int n;
    n = 0;
    while (p !== 1'b1 && n < 10) begin
      @(negedge core_clk_in);
      n++;
    end
  endtask : wait_pulse

  task wr(input logic [16:0] a, input logic [7:0] d);
    do_req(1'b1, a, d);
    wait_pulse(wr_done_out);
    check(wr_done_out, 1);
  endtask : wr

  task rd(input logic [16:0] a, input logic [7:0] e);
    do_req(1'b0, a, 8'h00);
    wait_pulse(rd_valid_out);
    check(rd_valid_out, 1);
    check(rd_data_out, e);
  endtask : rd

  // idle pins while in reset
  task t_reset;
    @(negedge core_clk_in);
    check({chip_select_low_active_n_out, chip_select_high_active_out, write_strobe_n_out,
      output_gate_n_out, data_bus_oe_out}, 5'h16);
  endtask : t_reset

  // end addresses, back to back, then overwrite
  task t_rw;
    logic [16:0] ad [4];
    logic [7:0] da [4];
    ad = '{17'h00000, 17'h1FFFF, 17'h0AAAA, 17'h15555};
    da = '{8'h3C, 8'hC3, 8'h5A, 8'hA5};
    for (int i = 0; i < 4; i++) wr(ad[i], da[i]);
    for (int i = 0; i < 4; i++) rd(ad[i], da[i]);
    wr(17'h00000, 8'hFF);
    rd(17'h00000, 8'hFF);
  endtask : t_rw

  // requests refused during retention, ready still low half a cycle after release, while still in retention
  task t_retain;
    @(posedge core_clk_in);
    retention_in <= 1'b1;
    req_valid_in <= 1'b1;
    req_write_in <= 1'b0;
    repeat (5) @(negedge core_clk_in);
    check(rd_valid_out, 0);
    check(chip_select_low_active_n_out, 1);
    @(posedge core_clk_in);
    retention_in <= 1'b0;
    req_valid_in <= 1'b0;
    @(negedge core_clk_in);
    check(req_ready_out, 0);
    rd(17'h1FFFF, 8'hC3);
  endtask : t_retain

  initial begin
    repeat (5000) @(posedge core_clk_in);
    num_errors++;
    finish_test();
  end

  initial begin
    repeat (3) @(posedge core_clk_in);
    t_reset();
    @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    t_rw();
    t_retain();
    finish_test();
  end
endmodule : tb_top
